// ==== rtl/msx_exec.sv ====
// execution slice top: apb command port, data ram, rom table port
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - decrement-skip: memory minus one written back, skip when zero
// - any skip discards next fetch, instruction takes two cycles, as do table reads, else one
// - decrement-to-acc: memory minus one into acc, memory kept, skip on zero
// - byte set writes all ones to memory, flags kept
// - bit set forces chosen bit to one, others and flags kept
// - increment-skip: memory plus one written back, skip on wrapped zero
// - increment-to-acc: memory plus one into acc, skip when zero
// - skip when chosen memory bit is one, nothing changes
// - memory subtract acc plus inverted mem plus one, acc or memory form
// - immediate subtract acc plus inverted immediate plus one into acc
// - in-place swap exchanges memory nibbles, flags kept
// - swap-to-acc puts exchanged nibbles in acc, memory kept
// - skip when memory byte is zero, nothing changes
// - copy memory into acc, skip when byte is zero
// - skip when chosen memory bit is zero, nothing changes
// - current-page table read: rom low byte to memory, high to table high
// - last-page table read same but from last rom page
// - xor acc with memory into acc, only zero flag changes
// - xor into memory, only zero flag changes
// - xor immediate into acc, only zero flag changes
module msx_exec
  import msx_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [ROM_AW-1:0]     rom_addr,
  input  wire logic [ROM_DW-1:0]     rom_data,
  output logic                       busy,
  output logic                       skip_dummy
);
  import msx_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ROM, ST_DUMMY} msx_state_t;

  logic [7:0]             ram [RAM_DEPTH];
  logic [7:0]             acc;
  logic [7:0]             next_acc;
  msx_flags_t             flags;
  msx_flags_t             next_flags;
  logic [7:0]             tbl_ptr;
  logic [7:0]             next_tbl_ptr;
  logic [TBH_W-1:0]       tbl_high;
  logic [TBH_W-1:0]       next_tbl_high;
  logic [1:0]             pc_hi;
  logic [1:0]             next_pc_hi;
  msx_state_t             state;
  msx_state_t             next_state;
  logic [ROM_AW-1:0]      next_rom_addr;
  logic                   next_busy;
  logic                   next_skip_dummy;
  logic                   last_skip;
  logic                   next_last_skip;
  logic [31:0]            next_prdata;
  logic                   next_pready;
  logic                   next_pslverr;
  logic                   ram_we;
  logic [RAM_AW-1:0]      ram_wa;
  logic [7:0]             ram_wd;
  msx_op_t                cur_op;
  logic [RAM_AW-1:0]      cur_addr;
  logic [RAM_AW-1:0]      hold_addr;
  logic [RAM_AW-1:0]      next_hold_addr;
  logic [7:0]             alu_res;
  logic                   alu_skip;
  logic                   alu_to_acc;
  logic                   alu_to_mem;
  msx_flags_t             alu_flags;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   is_ram;

  assign wr_acc   = psel && penable && pwrite && !pready;
  assign rd_acc   = psel && penable && !pwrite && !pready;
  assign cur_op   = msx_op_t'(pwdata[F_OP_LSB +: 5]);
  assign cur_addr = pwdata[F_ADDR_LSB +: RAM_AW];
  assign is_ram   = (paddr[11:10] == A_RAMWIN[11:10]) &&
                    (paddr[9:2] < 8'(RAM_DEPTH));

  msx_alu u_alu
  (
    .op        (cur_op),
    .acc       (acc),
    .mem       (ram[cur_addr]),
    .imm       (pwdata[F_IMM_LSB +: 8]),
    .bsel      (pwdata[F_BIT_LSB +: 3]),
    .flags_in  (flags),
    .res       (alu_res),
    .skip      (alu_skip),
    .to_acc    (alu_to_acc),
    .to_mem    (alu_to_mem),
    .flags_out (alu_flags)
  );

  always_comb
  begin
    next_acc        = acc;
    next_flags      = flags;
    next_tbl_ptr    = tbl_ptr;
    next_tbl_high   = tbl_high;
    next_pc_hi      = pc_hi;
    next_state      = state;
    next_rom_addr   = rom_addr;
    next_busy       = busy;
    next_skip_dummy = 1'b0;
    next_last_skip  = last_skip;
    next_hold_addr  = hold_addr;
    next_prdata     = prdata;
    next_pready     = 1'b0;
    next_pslverr    = 1'b0;
    ram_we          = 1'b0;
    ram_wa          = cur_addr;
    ram_wd          = alu_res;
    case (state)
      ST_IDLE:
      begin
        if (wr_acc)
        begin
          next_pready = 1'b1;
          case (paddr)
            A_CMD:
            begin
              if (cur_op == OP_TBL_CUR || cur_op == OP_TBL_LAST)
              begin
                next_hold_addr = cur_addr;
                next_rom_addr  = (cur_op == OP_TBL_CUR)
                               ? {pc_hi, tbl_ptr}
                               : {LAST_PAGE, tbl_ptr};
                next_state     = ST_ROM;
                next_busy      = 1'b1;
                next_last_skip = 1'b0;
              end
              else
              begin
                if (alu_to_acc)
                  next_acc = alu_res;
                ram_we         = alu_to_mem;
                next_flags     = alu_flags;
                next_last_skip = alu_skip;
                if (alu_skip)
                begin
                  next_state = ST_DUMMY;
                  next_busy  = 1'b1;
                end
              end
            end
            A_ACC:   next_acc = pwdata[7:0];
            A_FLAGS: next_flags = msx_flags_t'(pwdata[3:0]);
            A_TABLE_POINTER:  next_tbl_ptr = pwdata[7:0];
            A_PCHI:  next_pc_hi = pwdata[1:0];
            default:
            begin
              if (is_ram)
              begin
                ram_we = 1'b1;
                ram_wa = paddr[2 +: RAM_AW];
                ram_wd = pwdata[7:0];
              end
              else
                next_pslverr = 1'b1;
            end
          endcase
        end
        else if (rd_acc)
        begin
          next_pready = 1'b1;
          next_prdata = 32'h0;
          case (paddr)
            A_CMD:    next_prdata = 32'h0;
            A_STATUS: next_prdata = {30'h0, last_skip, busy};
            A_ACC:    next_prdata = {24'h0, acc};
            A_FLAGS:  next_prdata = {28'h0, flags};
            A_TABLE_POINTER:   next_prdata = {24'h0, tbl_ptr};
            A_TABLE_HIGH_BYTE_REG:   next_prdata = {26'h0, tbl_high};
            A_PCHI:   next_prdata = {30'h0, pc_hi};
            default:
            begin
              if (is_ram)
                next_prdata = {24'h0, ram[paddr[2 +: RAM_AW]]};
              else
                next_pslverr = 1'b1;
            end
          endcase
        end
      end
      ST_ROM:
      begin
        ram_we        = 1'b1;
        ram_wa        = hold_addr;
        ram_wd        = rom_data[7:0];
        next_tbl_high = rom_data[ROM_DW-1:DW];
        next_state    = ST_IDLE;
        next_busy     = 1'b0;
      end
      ST_DUMMY:
      begin
        next_skip_dummy = 1'b1;
        next_state      = ST_IDLE;
        next_busy       = 1'b0;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc        <= BYTE_ZERO;
      flags      <= '0;
      tbl_ptr    <= BYTE_ZERO;
      tbl_high   <= '0;
      pc_hi      <= 2'h0;
      state      <= ST_IDLE;
      rom_addr   <= '0;
      busy       <= 1'b0;
      skip_dummy <= 1'b0;
      last_skip  <= 1'b0;
      hold_addr  <= '0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end
    else
    begin
      acc        <= next_acc;
      flags      <= next_flags;
      tbl_ptr    <= next_tbl_ptr;
      tbl_high   <= next_tbl_high;
      pc_hi      <= next_pc_hi;
      state      <= next_state;
      rom_addr   <= next_rom_addr;
      busy       <= next_busy;
      skip_dummy <= next_skip_dummy;
      last_skip  <= next_last_skip;
      hold_addr  <= next_hold_addr;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // data ram has no reset, like the core's file
  always_ff @(posedge pclk)
  begin
    if (ram_we)
      ram[ram_wa] <= ram_wd;
  end
endmodule

// ==== rtl/msx_pkg.sv ====
// package for the skip, arithmetic, table and xor execution slice
package msx_pkg;
  localparam int          DW          = 8;
  localparam int          RAM_AW      = 5;
  localparam int          ROM_AW      = 10;
  localparam int          ROM_DW      = 14;
  localparam int          TBH_W       = ROM_DW - DW;
  localparam int          RAM_DEPTH   = 32;
  localparam int          PAGE_LOW_W  = 8;
  localparam logic [7:0]  BYTE_ONES   = 8'hff;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [1:0]  LAST_PAGE   = 2'h3;
  localparam int          ROM_WAIT_CY = 1;
  // apb register map
  localparam logic [11:0] A_CMD       = 12'h000;
  localparam logic [11:0] A_STATUS    = 12'h004;
  localparam logic [11:0] A_ACC       = 12'h008;
  localparam logic [11:0] A_FLAGS     = 12'h00c;
  localparam logic [11:0] A_TABLE_POINTER      = 12'h010;
  localparam logic [11:0] A_TABLE_HIGH_BYTE_REG      = 12'h014;
  localparam logic [11:0] A_PCHI      = 12'h018;
  localparam logic [11:0] A_RAMWIN    = 12'h400;
  // command register fields
  localparam int          F_OP_LSB    = 0;
  localparam int          F_ADDR_LSB  = 8;
  localparam int          F_BIT_LSB   = 13;
  localparam int          F_IMM_LSB   = 16;
  // flag register fields
  localparam int          F_C         = 0;
  localparam int          F_AC        = 1;
  localparam int          F_Z         = 2;
  localparam int          F_OV        = 3;

  typedef enum logic [4:0] {
    OP_NOP, OP_DEC_SKIP, OP_DEC_ACC_SKIP, OP_SET_BYTE, OP_SET_BIT,
    OP_INC_SKIP, OP_INC_ACC_SKIP, OP_SKIP_BIT_ONE, OP_SUB_M,
    OP_MINUS_INTO_MEM, OP_SUB_IMM, OP_SWAP, OP_NIBBLE_XCHG_ACC,
    OP_SKIP_NULL, OP_COPY_ACC_SKIP, OP_SKIP_BIT_ZERO, OP_TBL_CUR,
    OP_TBL_LAST, OP_XOR_M, OP_XOR_INTO_MEM, OP_XOR_IMM
  } msx_op_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } msx_flags_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } msx_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } msx_apb_rsp_t;
endpackage

// ==== rtl/msx_alu.sv ====
// combinational arithmetic and logic unit of the execution slice
`timescale 1ns/100ps
module msx_alu
  import msx_pkg::*;
(
  input  wire msx_op_t    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] mem,
  input  wire logic [7:0] imm,
  input  wire logic [2:0] bsel,
  input  wire msx_flags_t flags_in,
  output logic [7:0]      res,
  output logic            skip,
  output logic            to_acc,
  output logic            to_mem,
  output msx_flags_t      flags_out
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] sub_b;
  logic [7:0] bmask;

  always_comb
  begin
    bmask     = BYTE_ONE << bsel;
    sub_b     = (op == OP_SUB_IMM) ? ~imm : ~mem;
    sum       = {1'b0, acc} + {1'b0, sub_b} + 9'h001;
    lo        = {1'b0, acc[3:0]} + {1'b0, sub_b[3:0]} + 5'h01;
    res       = acc;
    skip      = 1'b0;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    flags_out = flags_in;
    case (op)
      OP_DEC_SKIP, OP_DEC_ACC_SKIP:
      begin
        res    = mem - BYTE_ONE;
        skip   = (res == BYTE_ZERO);
        to_mem = (op == OP_DEC_SKIP);
        to_acc = (op == OP_DEC_ACC_SKIP);
      end
      OP_INC_SKIP, OP_INC_ACC_SKIP:
      begin
        res    = mem + BYTE_ONE;
        skip   = (res == BYTE_ZERO);
        to_mem = (op == OP_INC_SKIP);
        to_acc = (op == OP_INC_ACC_SKIP);
      end
      OP_SET_BYTE:
      begin
        res    = BYTE_ONES;
        to_mem = 1'b1;
      end
      OP_SET_BIT:
      begin
        res    = mem | bmask;
        to_mem = 1'b1;
      end
      OP_SKIP_BIT_ONE:
        skip = |(mem & bmask);
      OP_SKIP_BIT_ZERO:
        skip = ~|(mem & bmask);
      OP_SKIP_NULL:
        skip = (mem == BYTE_ZERO);
      OP_COPY_ACC_SKIP:
      begin
        res    = mem;
        to_acc = 1'b1;
        skip   = (mem == BYTE_ZERO);
      end
      OP_SUB_M, OP_MINUS_INTO_MEM, OP_SUB_IMM:
      begin
        res          = sum[7:0];
        to_mem       = (op == OP_MINUS_INTO_MEM);
        to_acc       = (op != OP_MINUS_INTO_MEM);
        flags_out.c  = sum[8];
        flags_out.ac = lo[4];
        flags_out.z  = (sum[7:0] == BYTE_ZERO);
        flags_out.ov = (acc[7] == sub_b[7]) &&
                       (sum[7] != acc[7]);
      end
      OP_SWAP, OP_NIBBLE_XCHG_ACC:
      begin
        res    = {mem[3:0], mem[7:4]};
        to_mem = (op == OP_SWAP);
        to_acc = (op == OP_NIBBLE_XCHG_ACC);
      end
      OP_XOR_M, OP_XOR_INTO_MEM, OP_XOR_IMM:
      begin
        res         = acc ^ ((op == OP_XOR_IMM) ? imm : mem);
        to_mem      = (op == OP_XOR_INTO_MEM);
        to_acc      = (op != OP_XOR_INTO_MEM);
        flags_out.z = (res == BYTE_ZERO);
      end
      default:
        res = acc;
    endcase
  end
endmodule

// ==== testbench/msx_rom_model.sv ====
// behavioural program rom answering table reads of the execution slice
`timescale 1ns/100ps
module msx_rom_model
  import msx_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [ROM_AW-1:0] rom_addr,
  output logic      [ROM_DW-1:0] rom_data
);
  // asynchronous word, follows the registered address in the same cycle
  always_comb
  begin
    rom_data = {rom_addr[9:8] ^ 2'h2, rom_addr[3:0], rom_addr[7:0] ^ 8'ha5};
  end
endmodule

// ==== testbench/msx_exec_props.sv ====
// concurrent checks on the execution slice ports
`timescale 1ns/100ps
module msx_exec_props
  import msx_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic [ROM_DW-1:0] rom_data,
  input wire logic              busy,
  input wire logic              skip_dummy
);
  logic       cmd_wr;
  logic [4:0] op;
  logic       plain_op;
  assign cmd_wr = psel && penable && pwrite && pready && paddr == A_CMD;
  assign op = pwdata[4:0];
  assign plain_op = op inside {OP_SET_BYTE, OP_SET_BIT, OP_SUB_M,
    OP_MINUS_INTO_MEM, OP_SUB_IMM, OP_SWAP, OP_NIBBLE_XCHG_ACC,
    OP_XOR_M, OP_XOR_INTO_MEM, OP_XOR_IMM};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready && !busy;
  endsequence
  sequence s_rom_cycle;
    busy ##1 (!busy && !skip_dummy);
  endsequence
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_answer;
    s_take |=> pready;
  endproperty
  property p_busy_len;
    $rose(busy) |=> !busy;
  endproperty
  property p_dummy_one;
    skip_dummy |=> !skip_dummy;
  endproperty
  property p_dummy_cause;
    skip_dummy |-> $past(busy) && !busy;
  endproperty
  property p_plain;
    cmd_wr && plain_op |-> !busy ##1 !skip_dummy;
  endproperty
  property p_table;
    cmd_wr && (op == OP_TBL_CUR || op == OP_TBL_LAST) |-> s_rom_cycle;
  endproperty
  property p_last_page;
    cmd_wr && op == OP_TBL_LAST |-> rom_addr[9:8] == LAST_PAGE;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_answer: assert property (p_answer)
    else $error("access not answered in one cycle");
  a_busy_len: assert property (p_busy_len)
    else $error("busy longer than one cycle");
  a_dummy_one: assert property (p_dummy_one)
    else $error("dummy cycle longer than one cycle");
  a_dummy_cause: assert property (p_dummy_cause)
    else $error("dummy cycle without busy before it");
  a_plain: assert property (p_plain)
    else $error("non skip command took extra cycle");
  a_table: assert property (p_table)
    else $error("table read not two cycles");
  a_last_page: assert property (p_last_page)
    else $error("last page read from wrong page");
endmodule
bind msx_exec msx_exec_props i_msx_exec_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rom_addr, .rom_data, .busy, .skip_dummy);

// ==== testbench/msx_exec_tb_top.sv ====
// self-checking testbench for the execution slice
`timescale 1ns/100ps
module msx_exec_tb_top;
  import msx_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data;
  logic              busy;
  logic              skip_dummy;
  int                n_errors = 0;
  int                checks = 0;
  int                n_skip = 0;
  always #2 pclk = ~pclk;
  msx_exec i_msx_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rom_addr, .rom_data, .busy,
    .skip_dummy);
  msx_rom_model i_msx_rom_model (.pclk, .rom_addr, .rom_data);
  always @(posedge pclk) if (skip_dummy === 1'b1) n_skip++;
  function automatic logic [13:0] romw(input logic [9:0] a);
    return {a[9:8] ^ 2'h2, a[3:0], a[7:0] ^ 8'ha5};
  endfunction
  task final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task chk(input logic [11:0] a, input string nm, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(nm, x, q);
  endtask
  task run(input msx_op_t o, input logic [4:0] a, input logic [2:0] b,
           input logic [7:0] im, m, ac, input logic [3:0] fl,
           input logic [7:0] ea, em, input logic [3:0] ef, input logic es);
    int s0;
    wr(A_RAMWIN + {5'h0, a, 2'h0}, {24'h0, m});
    wr(A_ACC, {24'h0, ac});
    wr(A_FLAGS, {28'h0, fl});
    s0 = n_skip;
    wr(A_CMD, {8'h0, im, b, a, 3'h0, o});
    chk(A_ACC, "acc", {24'h0, ea});
    chk(A_RAMWIN + {5'h0, a, 2'h0}, "mem", {24'h0, em});
    chk(A_FLAGS, "flags", {28'h0, ef});
    cmp("skip", {31'h0, es}, 32'(n_skip - s0));
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [11:0] rv [5] = '{A_ACC, A_FLAGS, A_TABLE_POINTER, A_TABLE_HIGH_BYTE_REG, A_PCHI};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rv[i]) chk(rv[i], "reset", 32'h0);
    apb(1'b0, 12'h020, 32'h0, q, e);
    cmp("unmapped err", 32'h1, {31'h0, e});
    cmp("unmapped data", 32'h0, q);
    wr(A_PCHI, 32'h1);
    wr(A_TABLE_POINTER, 32'h37);
    run(OP_DEC_SKIP, 1, 0, 8'h00, 8'h01, 8'h33, 4'ha, 8'h33, 8'h00, 4'ha, 1);
    run(OP_DEC_SKIP, 31, 0, 8'h00, 8'h00, 8'h33, 4'h5, 8'h33, 8'hff, 4'h5, 0);
    run(OP_DEC_ACC_SKIP, 2, 0, 8'h00, 8'h01, 8'h33, 4'ha, 8'h00, 8'h01, 4'ha, 1);
    run(OP_SET_BYTE, 3, 0, 8'h00, 8'h12, 8'h44, 4'h5, 8'h44, 8'hff, 4'h5, 0);
    run(OP_SET_BIT, 4, 7, 8'h00, 8'h12, 8'h44, 4'ha, 8'h44, 8'h92, 4'ha, 0);
    run(OP_INC_SKIP, 5, 0, 8'h00, 8'hff, 8'h44, 4'h5, 8'h44, 8'h00, 4'h5, 1);
    run(OP_INC_ACC_SKIP, 6, 0, 8'h00, 8'h7f, 8'h44, 4'ha, 8'h80, 8'h7f, 4'ha, 0);
    run(OP_SKIP_BIT_ONE, 7, 3, 8'h00, 8'h08, 8'h11, 4'h5, 8'h11, 8'h08, 4'h5, 1);
    run(OP_SKIP_BIT_ONE, 7, 2, 8'h00, 8'h08, 8'h11, 4'h5, 8'h11, 8'h08, 4'h5, 0);
    run(OP_SUB_M, 8, 0, 8'h00, 8'h01, 8'h80, 4'h6, 8'h7f, 8'h01, 4'h9, 0);
    run(OP_MINUS_INTO_MEM, 9, 0, 8'h00, 8'h05, 8'h05, 4'h8, 8'h05, 8'h00, 4'h7, 0);
    run(OP_SUB_IMM, 10, 0, 8'h20, 8'h66, 8'h10, 4'hd, 8'hf0, 8'h66, 4'h2, 0);
    run(OP_SWAP, 11, 0, 8'h00, 8'ha5, 8'h22, 4'h5, 8'h22, 8'h5a, 4'h5, 0);
    run(OP_NIBBLE_XCHG_ACC, 12, 0, 8'h00, 8'h3c, 8'h22, 4'ha, 8'hc3, 8'h3c, 4'ha, 0);
    run(OP_SKIP_NULL, 13, 0, 8'h00, 8'h00, 8'h22, 4'h5, 8'h22, 8'h00, 4'h5, 1);
    run(OP_SKIP_NULL, 13, 0, 8'h00, 8'h01, 8'h22, 4'h5, 8'h22, 8'h01, 4'h5, 0);
    run(OP_COPY_ACC_SKIP, 14, 0, 8'h00, 8'h00, 8'h55, 4'ha, 8'h00, 8'h00, 4'ha, 1);
    run(OP_COPY_ACC_SKIP, 14, 0, 8'h00, 8'h4e, 8'h55, 4'ha, 8'h4e, 8'h4e, 4'ha, 0);
    run(OP_SKIP_BIT_ZERO, 15, 0, 8'h00, 8'hfe, 8'h22, 4'h5, 8'h22, 8'hfe, 4'h5, 1);
    chk(A_STATUS, "status", 32'h2);
    run(OP_XOR_M, 16, 0, 8'h00, 8'h0f, 8'hf0, 4'hf, 8'hff, 8'h0f, 4'hb, 0);
    run(OP_XOR_INTO_MEM, 17, 0, 8'h00, 8'h3c, 8'h3c, 4'h0, 8'h3c, 8'h00, 4'h4, 0);
    run(OP_XOR_IMM, 18, 0, 8'h55, 8'h99, 8'h55, 4'ha, 8'h00, 8'h99, 4'he, 0);
    run(OP_TBL_CUR, 19, 0, 8'h00, 8'h00, 8'h22, 4'h5, 8'h22, romw(10'h137), 4'h5, 0);
    chk(A_TABLE_HIGH_BYTE_REG, "table_high_byte_reg", 32'(romw(10'h137) >> 8));
    run(OP_TBL_LAST, 20, 0, 8'h00, 8'h00, 8'h22, 4'ha, 8'h22, romw(10'h337), 4'ha, 0);
    chk(A_TABLE_HIGH_BYTE_REG, "table_high_byte_reg", 32'(romw(10'h337) >> 8));
    final_report();
  end
endmodule
